// [design/flash_unlock_erase_control.sv]
// Flash lock and command gate: ordered unlock, single-page erase, debug-only mass erase.
// Assumes write strobes are one-cycle pulses on sys_clk from the register decoder.
//
// Operation
// - Unlock starts with a page select write, then 73h and 8Ch written to the command register.
// - Unlock completes when a final page select write repeats the earlier page value.
// - Any wrong value or out-of-order write returns the gate to locked.
// - While unlocked, a command write starts a page or mass erase.
// - A page erase targets only the page held in the page select register.
// - Mass erase is accepted only when written through the debug path.
// - One unlock allows one erase; a second erase needs a fresh unlock.
// - The page select register takes writes while unlocked.
// - The command register is write-only and reads back no command or state.
`timescale 1ns/1ps
`include "flash_gate_params.svh"
module flash_unlock_erase_control
	import flash_gate_pkg::*;
#(
	parameter int ERASE_LEN = `ERASE_CYCLES
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// Register writes from processor or debugger
	input  wire logic       page_wr,
	input  wire logic       cmd_wr,
	input  wire logic       from_debug,
	input  wire logic [7:0] wdata,
	// Command register read port
	output logic [7:0]      cmd_rdata,
	// Flash array side
	output logic            unlocked,
	output logic [7:0]      open_page,
	output logic            page_erase,
	output logic            mass_erase,
	output logic            erase_busy
);
	gate_state_t state;
	gate_state_t next_state;
	logic [7:0]  page_sel;
	logic [7:0]  next_page_sel;
	logic        next_page_erase;
	logic        next_mass_erase;
	logic        next_unlocked;
	logic        next_busy;
	logic        start_erase;
	logic        tmr_busy;
	logic        tmr_done;

	// Strobe qualified by an exact data code; shared by decode and checks
	function automatic logic code_hit(input logic strobe, input logic [7:0] data,
		input logic [7:0] code);
		return strobe && (data == code);
	endfunction : code_hit

	// Erase duration timer; its done pulse closes the gate again
	erase_timer #(
		.CYCLES (ERASE_LEN)
	) u_timer (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.start   (start_erase),
		.busy    (tmr_busy),
		.done    (tmr_done)
	);

	// Unlock sequencer and command decode
	always_comb begin
		next_state      = state;
		next_page_sel   = page_sel;
		next_page_erase = 1'b0;
		next_mass_erase = 1'b0;
		start_erase     = 1'b0;
		unique case (state)
			LOCKED: begin
				if (page_wr) begin
					next_page_sel = wdata;
					next_state    = GOT_PAGE;
				end
			end
			GOT_PAGE: begin
				if (cmd_wr) begin
					next_state = code_hit(cmd_wr, wdata, `UNLOCK_KEY1) ? GOT_KEY1 : LOCKED;
				end else if (page_wr) begin
					next_state = LOCKED;
				end
			end
			GOT_KEY1: begin
				if (cmd_wr) begin
					next_state = code_hit(cmd_wr, wdata, `UNLOCK_KEY2) ? GOT_KEY2 : LOCKED;
				end else if (page_wr) begin
					next_state = LOCKED;
				end
			end
			GOT_KEY2: begin
				if (page_wr) begin
					next_state = (wdata == page_sel) ? UNLOCKED : LOCKED;
				end else if (cmd_wr) begin
					next_state = LOCKED;
				end
			end
			UNLOCKED: begin
				// page writes accepted while open
				// A command in the same cycle wins, so an erase never sees a moving page
				if (page_wr && !cmd_wr) begin
					next_page_sel = wdata;
				end
				// start erase; mass via debug only
				if (cmd_wr) begin
					if (code_hit(cmd_wr, wdata, `CMD_PAGE_ERASE)) begin
						next_page_erase = 1'b1;
						start_erase     = 1'b1;
						next_state      = ERASING;
					end else if (code_hit(cmd_wr, wdata, `CMD_MASS_ERASE) && from_debug) begin
						next_mass_erase = 1'b1;
						start_erase     = 1'b1;
						next_state      = ERASING;
					end else begin
						next_state = LOCKED;
					end
				end
			end
			ERASING: begin
				if (tmr_done) begin
					next_state = LOCKED;
				end
			end
			default: next_state = LOCKED;
		endcase
		next_unlocked = (next_state == UNLOCKED);
		next_busy     = start_erase | (tmr_busy & ~tmr_done);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state      <= LOCKED;
			page_sel   <= `PAGE_RESET;
			page_erase <= 1'b0;
			mass_erase <= 1'b0;
			unlocked   <= 1'b0;
			erase_busy <= 1'b0;
			open_page  <= `PAGE_RESET;
			cmd_rdata  <= 8'h00;
		end else begin
			state      <= next_state;
			page_sel   <= next_page_sel;
			page_erase <= next_page_erase;
			mass_erase <= next_mass_erase;
			unlocked   <= next_unlocked;
			erase_busy <= next_busy;
			open_page  <= next_page_sel;
			cmd_rdata  <= 8'h00;
		end
	end

	// Checks
	AST_UNLOCK_SEQ: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == LOCKED && page_wr) ##1 (cmd_wr && wdata == `UNLOCK_KEY1)
		##1 (cmd_wr && wdata == `UNLOCK_KEY2) ##1 (page_wr && wdata == $past(page_sel, 1))
		|=> unlocked)
		else $error("Unlock sequence did not open gate");
	AST_CONFIRM_MATCH: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == GOT_KEY2 && page_wr && wdata != page_sel) |=> state == LOCKED)
		else $error("Mismatched confirm page unlocked gate");
	AST_BAD_KEY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == GOT_PAGE && cmd_wr && wdata != `UNLOCK_KEY1) |=> state == LOCKED)
		else $error("Bad key did not relock");
	AST_PAGE_START: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == UNLOCKED && cmd_wr && wdata == `CMD_PAGE_ERASE)
		|=> page_erase && erase_busy)
		else $error("Page erase not started");
	AST_PAGE_ONLY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		page_erase |-> open_page == $past(page_sel))
		else $error("Erase page differs from selection");
	AST_MASS_DEBUG: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mass_erase |-> $past(from_debug) && $past(state) == UNLOCKED)
		else $error("Mass erase without debugger");
	AST_ONE_PAGE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == ERASING && tmr_done) |=> state == LOCKED && !unlocked)
		else $error("Gate stayed open after erase");
	AST_PAGE_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == UNLOCKED && page_wr && !cmd_wr) |=> page_sel == $past(wdata) && unlocked)
		else $error("Page write refused while unlocked");
	AST_WRITE_ONLY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		cmd_rdata == 8'h00)
		else $error("Command register read back data");
	AST_RESET_LOCK: assert property (@(posedge sys_clk)
		$rose(reset_n) |-> state == LOCKED && !unlocked)
		else $error("Not locked after reset");
	AST_KEY2_BAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == GOT_KEY1 && cmd_wr && !code_hit(cmd_wr, wdata, `UNLOCK_KEY2))
		|=> state == LOCKED)
		else $error("Bad second key did not relock");
	AST_ORDER_BREAK: assert property (@(posedge sys_clk) disable iff (!reset_n)
		((state == GOT_PAGE || state == GOT_KEY1) && page_wr && !cmd_wr) |=> state == LOCKED)
		else $error("Out of order page write did not relock");
	AST_UNKNOWN_CMD: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == UNLOCKED && cmd_wr
		&& wdata != `CMD_PAGE_ERASE && wdata != `CMD_MASS_ERASE)
		|=> state == LOCKED && !unlocked)
		else $error("Unknown command left gate open");
	AST_NO_ERASE_LOCKED: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state != UNLOCKED) |=> !page_erase && !mass_erase)
		else $error("Erase started while locked");
	AST_BUSY_END: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(erase_busy) |-> state == LOCKED && !unlocked)
		else $error("Gate not locked when erase ended");

	// Scenario coverage
	COV_UNLOCK: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(unlocked));
	COV_PAGE: cover property (@(posedge sys_clk) disable iff (!reset_n) page_erase);
	COV_MASS: cover property (@(posedge sys_clk) disable iff (!reset_n) mass_erase);
	COV_RELOCK: cover property (@(posedge sys_clk) disable iff (!reset_n)
		state == GOT_KEY1 ##1 state == LOCKED);
endmodule : flash_unlock_erase_control

// [design/flash_gate_params.svh]
// Constants for the flash lock and command gate.
// Included by the gate and erase timer design files; definitions only.
`ifndef FLASH_GATE_PARAMS_SVH
`define FLASH_GATE_PARAMS_SVH

`define UNLOCK_KEY1      8'h73
`define UNLOCK_KEY2      8'h8c
`define CMD_PAGE_ERASE   8'h95
`define CMD_MASS_ERASE   8'h63
`define PAGE_RESET       8'h00
`define ERASE_CYCLES     16'd64

`endif

// [design/flash_gate_pkg.sv]
// Types for the flash lock and command gate.
// Assumes the params header sits beside it.
package flash_gate_pkg;
	typedef enum logic [2:0] {
		LOCKED   = 3'b000,
		GOT_PAGE = 3'b001,
		GOT_KEY1 = 3'b011,
		GOT_KEY2 = 3'b010,
		UNLOCKED = 3'b110,
		ERASING  = 3'b111
	} gate_state_t;
endpackage : flash_gate_pkg

// [design/erase_timer.sv]
// Erase duration counter for the flash gate.
// Assumes one-cycle start pulses from the sequencer on the same clock.
`timescale 1ns/1ps
`include "flash_gate_params.svh"
module erase_timer #(
	parameter int CYCLES = `ERASE_CYCLES
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset_n,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	logic [15:0] count;
	logic [15:0] next_count;
	logic        next_done;

	// Count down while an erase runs
	always_comb begin
		next_count = count;
		next_done  = 1'b0;
		if (start) begin
			next_count = 16'(CYCLES);
		end else if (count != 16'h0000) begin
			next_count = count - 16'h0001;
			next_done  = (count == 16'h0001);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 16'h0000;
			done  <= 1'b0;
		end else begin
			count <= next_count;
			done  <= next_done;
		end
	end

	assign busy = (count != 16'h0000);
endmodule : erase_timer

// [verification/soft_writer.sv]
// Write source standing in for processor software and the debugger.
// Assumes the bench raises go for one cycle per write, set on a rising edge.
`timescale 1ns/1ps
module soft_writer (
	// Clock
	input  wire logic       sys_clk,
	// Request from bench
	input  wire logic       go,
	input  wire logic       to_cmd,
	input  wire logic       dbg,
	input  wire logic [7:0] val,
	// Gate write port
	output logic            page_wr,
	output logic            cmd_wr,
	output logic            from_debug,
	output logic [7:0]      wdata
);
	always_ff @(posedge sys_clk) begin
		page_wr    <= go & ~to_cmd;
		cmd_wr     <= go & to_cmd;
		from_debug <= go & dbg;
		wdata      <= go ? val : ~wdata; // Idle data never repeats from one cycle to the next
	end
endmodule : soft_writer

// [verification/flash_unlock_erase_control_tb_top.sv]
// Bench for the flash lock and command gate.
// Assumes the writer model turns each request into one strobe a cycle later.
`timescale 1ns/1ps
module flash_unlock_erase_control_tb_top;
	localparam int ERASE_LEN_TB = 4;
	logic       sys_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       go = 1'b0, to_cmd = 1'b0, dbg = 1'b0;
	logic [7:0] val = 8'h00, rnd = 8'h40, p, pe_page, cmd_rdata, open_page, wdata;
	logic       page_wr, cmd_wr, from_debug, unlocked, page_erase, mass_erase, erase_busy;
	int         bad_count = 0, checks_done = 0, cyc = 0, pe_n = 0, me_n = 0, n_pe, v;
	int         busy_n = 0;

	soft_writer wr_model (.sys_clk(sys_clk), .go(go), .to_cmd(to_cmd), .dbg(dbg),
		.val(val), .page_wr(page_wr), .cmd_wr(cmd_wr), .from_debug(from_debug),
		.wdata(wdata));
	flash_unlock_erase_control #(.ERASE_LEN(ERASE_LEN_TB)) uut (.sys_clk(sys_clk),
		.reset_n(reset_n),
		.page_wr(page_wr), .cmd_wr(cmd_wr), .from_debug(from_debug), .wdata(wdata),
		.cmd_rdata(cmd_rdata), .unlocked(unlocked), .open_page(open_page),
		.page_erase(page_erase), .mass_erase(mass_erase), .erase_busy(erase_busy));

	// Clock
	initial forever #5 sys_clk = ~sys_clk;

	// Erase pulse tally and run limit
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (page_erase === 1'b1) begin
			pe_n <= pe_n + 1;
			pe_page <= open_page;
		end
		if (mass_erase === 1'b1)
			me_n <= me_n + 1;
		if (erase_busy === 1'b1)
			busy_n <= busy_n + 1;
		if (cyc == 2000) begin
			bad_count++;
			test_done();
		end
	end

	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// Gate opens only for both keys in order and a repeated page value
	function logic unlock_ok(input logic [7:0] a, k1, k2, b);
		return (a == b) && (k1 == 8'h73) && (k2 == 8'h8c);
	endfunction : unlock_ok

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic c, input logic d, input logic [7:0] x);
		go <= 1;
		to_cmd <= c;
		dbg <= d;
		val <= x;
		@(posedge sys_clk);
	endtask : wr

	task pause(input int n);
		go <= 0;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : pause

	task unlock(input logic [7:0] a, k1, k2, b);
		wr(0, 0, a);
		wr(1, 0, k1);
		wr(1, 0, k2);
		wr(0, 0, b);
		pause(3);
		chk({7'h0, unlocked}, {7'h0, unlock_ok(a, k1, k2, b)});
	endtask : unlock

	task test_done;
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// Main sequence: random unlock variants, then corner cases
	initial begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1;
		pause(1);
		chk({4'h0, unlocked, page_erase, mass_erase, erase_busy}, 8'h00);
		chk(open_page, 8'h00);
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			p = rnd;
			rnd = lfsr(rnd);
			v = (i < 4) ? i : rnd % 4;
			unlock(p, v == 1 ? 8'h73 ^ rnd : 8'h73, v == 2 ? 8'h8c ^ rnd : 8'h8c, v == 3 ? ~p : p);
			n_pe = pe_n + (v == 0);
			wr(1, 0, 8'h95);
			pause(10);
			chk(pe_n[7:0], n_pe[7:0]);
			if (v == 0)
				chk(pe_page, p);
			chk({7'h0, unlocked}, 8'h00);
		end
		unlock(8'h21, 8'h73, 8'h8c, 8'h21);
		chk(cmd_rdata, 8'h00);
		wr(0, 0, 8'h5a);
		pause(2);
		chk(open_page, 8'h5a);
		n_pe = pe_n + 1;
		wr(1, 0, 8'h95);
		pause(10);
		chk(pe_page, 8'h5a);
		wr(1, 0, 8'h95);
		pause(10);
		chk(pe_n[7:0], n_pe[7:0]);
		for (int d = 0; d < 2; d++) begin
			unlock(8'h07, 8'h73, 8'h8c, 8'h07);
			wr(1, d[0], 8'h63);
			pause(10);
			chk(me_n[7:0], d[7:0]);
			chk({7'h0, unlocked}, 8'h00);
		end
		// Repeated page write breaks the order; the keys then land while locked
		wr(0, 0, 8'h12);
		wr(0, 0, 8'h12);
		wr(1, 0, 8'h73);
		wr(1, 0, 8'h8c);
		wr(0, 0, 8'h12);
		pause(3);
		chk({7'h0, unlocked}, 8'h00);
		wr(1, 0, 8'h00);
		pause(2);
		// Reset in mid-run while unlocked closes the gate and clears the page
		unlock(8'h44, 8'h73, 8'h8c, 8'h44);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		pause(1);
		chk({7'h0, unlocked}, 8'h00);
		chk(open_page, 8'h00);
		unlock(8'h33, 8'h73, 8'h8c, 8'h33);
		wr(1, 0, 8'h00);
		pause(3);
		chk({7'h0, unlocked}, 8'h00);
		chk(busy_n[7:0], 8'((pe_n + me_n) * (ERASE_LEN_TB + 1)));
		test_done();
	end
endmodule : flash_unlock_erase_control_tb_top
